// ---- fbcs_host_model.sv ----
`timescale 1ns/1ps
// memory controller side: reports idle one cycle after it stops issuing work
module fbcs_host_model (
   input wire logic clk_i, // system clock
   input wire logic busy_i, // controller busy
   output logic idle_o // device idle seen by the block
);
   // block only accepts register loads while idle
   always_ff @(posedge clk_i) idle_o <= !busy_i;
endmodule : fbcs_host_model

// ---- fbcs_params.svh ----
`ifndef FBCS_PARAMS_SVH
`define FBCS_PARAMS_SVH
// register byte offsets on the wishbone slave
`define FBCS_OFF_NV 4'h0
`define FBCS_OFF_VOL 4'h4
`define FBCS_OFF_ACTIVE 4'h8
`define FBCS_OFF_CMD 4'hc
// command register bits
`define FBCS_CMD_SWRST 0
`define FBCS_CMD_ERASE 1
// status field of the active register
`define FBCS_ST_SEL 16
`define FBCS_ST_LOAD 17
`define FBCS_ST_LOCK 18
// field positions shared by both copies
`define FBCS_DRV_HI 14
`define FBCS_DRV_LO 12
`define FBCS_FRZ 11
`define FBCS_SSRF 10
`define FBCS_MAP_HI 9
`define FBCS_MAP_LO 8
`define FBCS_LAT_HI 7
`define FBCS_LAT_LO 4
`define FBCS_STALL 2
`define FBCS_BL_HI 1
`define FBCS_BL_LO 0
// factory default and erased values
`define FBCS_DEFAULT 16'h8ebb
`define FBCS_ERASED 16'hffff
// base latency in clocks for code zero
`define FBCS_LAT_BASE 5'h05
`endif

// ---- fbcs_pkg.sv ----
package fbcs_pkg;
   // burst length selection
   typedef enum logic [1:0] {
      BL_RSVD = 2'h0,
      BL_64 = 2'h1,
      BL_16 = 2'h2,
      BL_32 = 2'h3
   } fbcs_bl_e;
   // complete state of the block
   typedef struct packed {
      logic [15:0] nv;      // nonvolatile copy
      logic [15:0] vol;     // volatile copy
      logic sel;            // 1: volatile copy drives bus
      logic loaded;         // volatile loaded since reset
      logic perm_lock;      // locked at last reset
      logic ack;            // wishbone ack
      logic [31:0] rdat;    // wishbone read data
      logic [15:0] act;     // active config
   } fbcs_state_s;
endpackage : fbcs_pkg

// ---- fbcs_properties.sv ----
`timescale 1ns/1ps
module fbcs_checker (
   input wire logic CLK_SYS_I, ARST_N_I, WB_CYC_I, WB_STB_I, WB_WE_I, IDLE_I, WB_ACK_O,
   input wire logic [3:0] WB_ADR_I, WB_SEL_I,
   input wire logic [31:0] WB_DAT_I, WB_DAT_O,
   input wire logic [2:0] DRIVE_STRENGTH_O,
   input wire logic SECURE_REGION_WE_O, STROBE_NO_STALL_O, CONFIG_LOCKED_O,
   input wire logic [1:0] SECTOR_MAP_O, BURST_LEN_O,
   input wire logic [4:0] READ_LATENCY_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!ARST_N_I);
   // request taken this edge, and a write that must land
   wire tk = WB_CYC_I & WB_STB_I & !WB_ACK_O;
   wire wr = tk & WB_WE_I;
   wire ok = wr & IDLE_I & !CONFIG_LOCKED_O & (WB_SEL_I[1:0] == 2'h3);
   wire [14:0] cfg = {DRIVE_STRENGTH_O, SECURE_REGION_WE_O, SECTOR_MAP_O, READ_LATENCY_O,
      STROBE_NO_STALL_O, BURST_LEN_O, CONFIG_LOCKED_O};
   ack_delay_a: assert property (tk |=> WB_ACK_O) else $error("ack late");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
   vol_load_a: assert property (ok && WB_ADR_I == 4'h4 |=>
      DRIVE_STRENGTH_O == $past(WB_DAT_I[14:12]) && BURST_LEN_O == $past(WB_DAT_I[1:0])
      && READ_LATENCY_O == 5'h05 + {1'h0, $past(WB_DAT_I[7:4])}) else $error("vol load");
   frozen_write_a: assert property (wr && CONFIG_LOCKED_O |=> $stable(cfg))
      else $error("frozen write");
   busy_write_a: assert property (wr && !IDLE_I |=> $stable(cfg)) else $error("busy");
   lock_hold_a: assert property (CONFIG_LOCKED_O |=> CONFIG_LOCKED_O) else $error("lk");
   quiet_cfg_a: assert property (!wr |=> $stable(cfg)) else $error("cfg moved");
   nv_prog_a: assert property (wr && WB_ADR_I == 4'h0 |=> $stable(cfg)) else $error("nv");
   // main scenarios
   c_vol: cover property (ok && WB_ADR_I == 4'h4);
   c_lock: cover property ($rose(CONFIG_LOCKED_O));
   c_busy: cover property (wr && !IDLE_I);
endmodule : fbcs_checker
bind fbcs_top fbcs_checker u_chk (.*);

// ---- fbcs_top.sv ----
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "fbcs_params.svh"
module fbcs_top #(
   parameter logic [15:0] NV_INIT = `FBCS_DEFAULT // nonvolatile content at power-up
) (
   input wire logic CLK_SYS_I,          // system clock 200 MHz
   input wire logic ARST_N_I,           // async reset, power-up or hardware reset
   input wire logic WB_CYC_I,           // wishbone cycle
   input wire logic WB_STB_I,           // wishbone strobe
   input wire logic WB_WE_I,            // wishbone write enable
   input wire logic [3:0] WB_ADR_I,     // byte address
   input wire logic [3:0] WB_SEL_I,     // byte selects
   input wire logic [31:0] WB_DAT_I,    // write data
   output logic [31:0] WB_DAT_O,        // read data
   output logic WB_ACK_O,               // acknowledge
   input wire logic IDLE_I,             // device idle, no embedded operation
   output logic [2:0] DRIVE_STRENGTH_O, // output impedance code
   output logic SECURE_REGION_WE_O,     // secure silicon region programmable
   output logic [1:0] SECTOR_MAP_O,     // parameter sector mapping
   output logic [4:0] READ_LATENCY_O,   // initial latency in clocks
   output logic STROBE_NO_STALL_O,      // strobe keeps toggling after dual error
   output logic [1:0] BURST_LEN_O,      // wrapped burst length code
   output logic CONFIG_LOCKED_O         // changes to both copies refused
);

   fbcs_pkg::fbcs_state_s s_q; // registered state
   fbcs_pkg::fbcs_state_s s_d; // next state

   // merge a 16-bit value with low byte lanes of a write
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction : lane_merge

   logic req;       // new bus access, not yet acked
   logic wr;        // write access
   logic frz_open;  // changes currently allowed
   logic [15:0] nv_new;  // candidate nonvolatile value
   logic [15:0] vol_new; // candidate volatile value

   // next state computation
   always_comb begin
      s_d = s_q;
      req = WB_CYC_I && WB_STB_I && !s_q.ack;
      wr = req && WB_WE_I;
      // freeze read from the copy now in use; permanent lock overrides
      frz_open = s_q.act[`FBCS_FRZ] && !s_q.perm_lock;
      nv_new = lane_merge(s_q.nv, WB_DAT_I, WB_SEL_I);
      vol_new = lane_merge(s_q.vol, WB_DAT_I, WB_SEL_I);
      s_d.ack = req;
      s_d.rdat = 32'h0;
      if (req && !WB_WE_I) begin
         // read mux; unmapped offsets read zero
         case (WB_ADR_I)
            `FBCS_OFF_NV: s_d.rdat = {16'h0, s_q.nv};
            `FBCS_OFF_VOL: s_d.rdat = {16'h0, s_q.vol};
            `FBCS_OFF_ACTIVE: begin
               s_d.rdat = {16'h0, s_q.act};
               s_d.rdat[`FBCS_ST_SEL] = s_q.sel;
               s_d.rdat[`FBCS_ST_LOAD] = s_q.loaded;
               s_d.rdat[`FBCS_ST_LOCK] = !frz_open;
            end
            default: s_d.rdat = 32'h0;
         endcase
      end
      if (wr && frz_open && IDLE_I) begin
         case (WB_ADR_I)
            `FBCS_OFF_VOL: begin
               // volatile load takes effect at once and selects it
               s_d.vol = vol_new;
               s_d.loaded = 1'b1;
               s_d.sel = 1'b1;
            end
            `FBCS_OFF_NV: begin
               // nonvolatile program; active config untouched, and reset reloads NV_INIT, not this value
               s_d.nv = nv_new;
               if (!s_q.loaded) begin
                  s_d.vol = nv_new;
               end
            end
            `FBCS_OFF_CMD: begin
               if (WB_SEL_I[0] && WB_DAT_I[`FBCS_CMD_ERASE]) begin
                  s_d.nv = `FBCS_ERASED; // erase keeps volatile
               end
            end
            default: s_d = s_d;
         endcase
      end
      // software reset leaves select and copies alone
      if (wr && WB_ADR_I == `FBCS_OFF_CMD && WB_SEL_I[0] && WB_DAT_I[`FBCS_CMD_SWRST]) begin
         s_d.sel = s_q.sel;
      end
      // active config follows the selected copy, nv contribution frozen
      s_d.act = s_d.sel ? s_d.vol : s_q.act;
      if (s_q.sel && !s_d.sel) begin
         s_d.act = s_q.act; // unreachable by design, select only rises
      end
   end

   // state register; reset reloads both copies and active config from NV_INIT
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         s_q.nv <= NV_INIT;
         s_q.vol <= NV_INIT;      // volatile mirrors nv after reset
         s_q.sel <= 1'b0;
         s_q.loaded <= 1'b0;
         s_q.perm_lock <= ~NV_INIT[`FBCS_FRZ];
         s_q.ack <= 1'b0;
         s_q.rdat <= 32'h0;
         s_q.act <= NV_INIT;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs decoded from active config, plus registered ack and read data
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         DRIVE_STRENGTH_O <= NV_INIT[`FBCS_DRV_HI:`FBCS_DRV_LO];
         SECURE_REGION_WE_O <= NV_INIT[`FBCS_SSRF];
         SECTOR_MAP_O <= NV_INIT[`FBCS_MAP_HI:`FBCS_MAP_LO];
         READ_LATENCY_O <= `FBCS_LAT_BASE + {1'b0, NV_INIT[`FBCS_LAT_HI:`FBCS_LAT_LO]};
         STROBE_NO_STALL_O <= NV_INIT[`FBCS_STALL];
         BURST_LEN_O <= NV_INIT[`FBCS_BL_HI:`FBCS_BL_LO];
         CONFIG_LOCKED_O <= ~NV_INIT[`FBCS_FRZ];
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0;
      end else begin
         DRIVE_STRENGTH_O <= s_d.act[`FBCS_DRV_HI:`FBCS_DRV_LO];
         SECURE_REGION_WE_O <= s_d.act[`FBCS_SSRF];
         SECTOR_MAP_O <= s_d.act[`FBCS_MAP_HI:`FBCS_MAP_LO];
         READ_LATENCY_O <= `FBCS_LAT_BASE + {1'b0, s_d.act[`FBCS_LAT_HI:`FBCS_LAT_LO]};
         STROBE_NO_STALL_O <= s_d.act[`FBCS_STALL];
         BURST_LEN_O <= s_d.act[`FBCS_BL_HI:`FBCS_BL_LO];
         CONFIG_LOCKED_O <= !(s_d.act[`FBCS_FRZ] && !s_d.perm_lock);
         WB_ACK_O <= s_d.ack;
         WB_DAT_O <= s_d.rdat;
      end
   end

endmodule : fbcs_top

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
   logic CLK_SYS_I = 1'h0, ARST_N_I = 1'h0, WB_CYC_I = 1'h0, WB_STB_I = 1'h0, WB_WE_I = 1'h0;
   logic [3:0] WB_ADR_I = 4'h0, WB_SEL_I = 4'h3;
   logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
   logic WB_ACK_O, IDLE_I, SECURE_REGION_WE_O, STROBE_NO_STALL_O, CONFIG_LOCKED_O;
   logic busy = 1'h0; // stalls the host model
   logic [2:0] DRIVE_STRENGTH_O;
   logic [1:0] SECTOR_MAP_O, BURST_LEN_O;
   logic [4:0] READ_LATENCY_O;
   int err_total = 0, n_tests = 0;
   fbcs_top dut (.*);
   fbcs_host_model host (.clk_i(CLK_SYS_I), .busy_i(busy), .idle_o(IDLE_I));
   initial forever #2.5 CLK_SYS_I = ~CLK_SYS_I;
   wire [14:0] cfg = {DRIVE_STRENGTH_O, SECURE_REGION_WE_O, SECTOR_MAP_O, READ_LATENCY_O,
      STROBE_NO_STALL_O, BURST_LEN_O, CONFIG_LOCKED_O};
   // expected decoded outputs for a config word and lock state
   function automatic logic [31:0] dec(logic [15:0] v, logic lk);
      return {17'h0, v[14:12], v[10], v[9:8], 5'h05 + {1'h0, v[7:4]}, v[2], v[1:0], lk};
   endfunction : dec
   task automatic chk(logic [31:0] e, logic [31:0] a);
      n_tests++;
      if (a !== e) begin
         err_total++;
         $display("[FAIL] %0t exp %h got %h", $time, e, a);
      end
   endtask : chk
   task complete_run;
      $display("mismatches %0d comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   // classic single wishbone cycle, bounded wait for ack
   task automatic wb(logic we, logic [3:0] a, logic [31:0] d);
      int n;
      @(posedge CLK_SYS_I);
      {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'h3, we, a, d};
      n = 0;
      do begin
         @(posedge CLK_SYS_I);
         n++;
      end while (WB_ACK_O !== 1'h1 && n < 20);
      rd = WB_DAT_O;
      {WB_CYC_I, WB_STB_I} <= 2'h0;
      if (n >= 20) begin
         err_total++;
         complete_run();
      end
   endtask : wb
   task t_boot;
      chk(dec(16'h8ebb, 0), cfg);
      wb(0, 4'h8, 0); chk(32'h8ebb, rd);
      wb(0, 4'h2, 0); chk(32'h0, rd);
   endtask : t_boot
   task t_nv;
      wb(1, 4'h0, 32'h8e4a); chk(dec(16'h8ebb, 0), cfg);
      wb(0, 4'h4, 0); chk(32'h8e4a, rd);
   endtask : t_nv
   task t_vol;
      wb(1, 4'h4, 32'h8b32); chk(dec(16'h8b32, 0), cfg);
      wb(1, 4'h4, 32'hfc15); chk(dec(16'hfc15, 0), cfg);
      wb(0, 4'h8, 0); chk(32'h3fc15, rd);
   endtask : t_vol
   task t_sw;
      wb(1, 4'hc, 32'h1); wb(0, 4'h8, 0); chk(32'h3fc15, rd);
      wb(1, 4'hc, 32'h2); wb(0, 4'h4, 0); chk(32'hfc15, rd);
      wb(0, 4'h0, 0); chk(32'hffff, rd);
   endtask : t_sw
   task t_busy;
      busy <= 1'h1;
      wb(1, 4'h4, 32'h8ebb); chk(dec(16'hfc15, 0), cfg);
      busy <= 1'h0;
   endtask : t_busy
   task t_frz;
      wb(1, 4'h4, 32'hf7bb); chk(dec(16'hf7bb, 1), cfg);
      wb(1, 4'h4, 32'h8ebb); chk(dec(16'hf7bb, 1), cfg);
   endtask : t_frz
   initial begin
      repeat (3) @(posedge CLK_SYS_I);
      ARST_N_I <= 1'h1;
      t_boot(); t_nv(); t_vol(); t_sw(); t_busy(); t_frz();
      ARST_N_I <= 1'h0;
      repeat (3) @(posedge CLK_SYS_I);
      ARST_N_I <= 1'h1;
      t_boot();
      complete_run();
   end
endmodule : testbench
